// [verilog/position_status_signals.sv]
// Terminal status logic for positioning, with AXI4-Lite setting registers.
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps

// Overview of operation
// R1: stop, stroke inputs trigger sudden-stop deceleration; here stroke inputs only while motion.pos_ctrl_sel is set.
// R2: travel done when idle and droop within width.
// R3: limit warning while either stroke end active.
// R4: in-position while droop at most set width.
// R5: home fail follows home return warning.
// R6: busy throughout position command operation.
// R7: home done set when home return finishes.
// R8: ready only with servo-lock and drive able.
// R9: servo-lock off clears home done if 9999.
// R10: other retention values keep home done set.
// R11: stop decel time 0.01 to 360 s.
// R12: direct mode select accepts 0 or variant value.
// R13: network position data used directly in direct mode.
// R14: logic select digits pick normally open or closed.
// R15: negative code drives inverse of positive level.
module position_status_signals #(
	parameter logic [7:0] DCMD_ON = 8'h03
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	// AXI4-Lite slave
	input wire logic [pos_status_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [pos_status_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Terminals
	input wire logic [pos_status_pkg::NUM_IN-1:0] in_term,
	output logic [pos_status_pkg::NUM_OUT-1:0] out_term,
	// Positioning core
	input wire pos_status_pkg::motion_status_t motion,
	input wire pos_status_pkg::pos_data_t table_data,
	input wire pos_status_pkg::pos_data_t net_data,
	output pos_status_pkg::pos_data_t pos_data,
	output logic decel_stop_req,
	output logic [pos_status_pkg::SET_W-1:0] stop_decel_time,
	output logic direct_mode,
	output logic proximity_dog_input,
	output logic irq
);
	import pos_status_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		logic [NUM_IN-1:0] in_s1;
		logic [NUM_IN-1:0] in_s2;
		logic [NUM_IN*FCODE_W-1:0] in_func;
		logic [NUM_OUT*FCODE_W-1:0] out_func;
		logic [LOGIC_W-1:0] terminal_input_logic_select;
		logic [SET_W-1:0] sudden_stop_decel_time;
		logic [SET_W-1:0] in_position_width;
		logic [SET_W-1:0] done_width;
		logic [SET_W-1:0] position_retention_select;
		logic [FCODE_W-1:0] direct_command_select;
		logic [IRQ_W-1:0] irq_st;
		logic [IRQ_W-1:0] irq_msk;
		logic aw_held;
		logic [ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic stop_req;
		logic travel_done_out;
		logic limit_warning_out;
		logic in_position_out;
		logic home_fail_out;
		logic positioning_busy_out;
		logic home_done_out;
		logic ready_out;
		logic dog;
		logic [NUM_OUT-1:0] out;
		pos_data_t pdata;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				m[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return m;
	endfunction

	// ==========================================================
	// Input terminal decoding
	logic [NUM_IN-1:0] hit_stop, hit_fwd, hit_rev, hit_dog;
	logic stop_act, fwd_act, rev_act;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_IN; gi++) begin : g_in
			logic [FCODE_W-1:0] code;
			logic lvl;
			assign code = st_r.in_func[gi*FCODE_W +: FCODE_W];
			assign lvl = st_r.in_s2[gi];
			// Stop, forward and reverse polarity from the logic select digits; dog has none. (see R14)
			assign hit_stop[gi] = (code == FC_STOP) &&
				(lvl ^ st_r.terminal_input_logic_select[LOGIC_STOP_BIT]);
			assign hit_fwd[gi] = (code == FC_FWD) &&
				(lvl ^ st_r.terminal_input_logic_select[LOGIC_FWD_BIT]);
			assign hit_rev[gi] = (code == FC_REV) &&
				(lvl ^ st_r.terminal_input_logic_select[LOGIC_REV_BIT]);
			assign hit_dog[gi] = (code == FC_DOG) && lvl;
		end
	endgenerate

	assign stop_act = |hit_stop;
	assign fwd_act = |hit_fwd;
	assign rev_act = |hit_rev;

	// ==========================================================
	// Status levels
	logic inpos_now, done_now, hdone_clear;
	logic [6:0] sig_pos;

	assign inpos_now = motion.droop <= DROOP_W'(st_r.in_position_width);
	assign done_now = motion.droop <= DROOP_W'(st_r.done_width);
	assign hdone_clear = !motion.servo_lock &&
		(st_r.position_retention_select == RETAIN_OFF);

	function automatic logic pick(input logic [FCODE_W-1:0] c,
		input logic [6:0] s);
		logic p;
		logic [FCODE_W-1:0] b;
		p = 1'b0;
		b = (c >= OC_NEG_OFS) ? c - OC_NEG_OFS : c;
		case (b)
			OC_TRAVEL: p = s[0];
			OC_LIMIT: p = s[1];
			OC_INPOS: p = s[2];
			OC_HFAIL: p = s[3];
			OC_BUSY: p = s[4];
			OC_HDONE: p = s[5];
			OC_READY: p = s[6];
			default: p = 1'b0;
		endcase
		// Negative-logic codes invert the positive level. (see R15)
		return (c >= OC_NEG_OFS) ? !p : p;
	endfunction

	// ==========================================================
	// Next state
	logic aw_take, w_take, ar_take, do_wr;
	logic [IRQ_W-1:0] ev;
	logic [31:0] rd;
	logic rd_ok;

	always_comb begin
		st_nxt = st_r;
		aw_take = s_axi_awvalid && !st_r.aw_held && !st_r.bvalid;
		w_take = s_axi_wvalid && !st_r.w_held && !st_r.bvalid;
		ar_take = s_axi_arvalid && !st_r.rvalid;
		do_wr = st_r.aw_held && st_r.w_held && !st_r.bvalid;
		rd = 32'h0;
		rd_ok = 1'b1;

		st_nxt.in_s1 = in_term;
		st_nxt.in_s2 = st_r.in_s1;
		st_nxt.dog = |hit_dog;

		st_nxt.stop_req = stop_act ||
			(motion.pos_ctrl_sel && (fwd_act || rev_act)); // see R1
		st_nxt.travel_done_out = !motion.busy && done_now; // see R2
		st_nxt.limit_warning_out = fwd_act || rev_act; // see R3
		st_nxt.in_position_out = inpos_now; // see R4
		st_nxt.home_fail_out = motion.home_warn; // see R5
		st_nxt.positioning_busy_out = motion.busy; // see R6
		if (motion.home_finish) begin
			st_nxt.home_done_out = 1'b1; // see R7
		end else if (hdone_clear) begin
			st_nxt.home_done_out = 1'b0; // see R9 see R10
		end
		st_nxt.ready_out = motion.servo_lock && motion.drive_ok; // see R8

		sig_pos = {st_nxt.ready_out, st_nxt.home_done_out,
			st_nxt.positioning_busy_out, st_nxt.home_fail_out,
			st_nxt.in_position_out, st_nxt.limit_warning_out,
			st_nxt.travel_done_out};
		for (int i = 0; i < NUM_OUT; i++) begin
			st_nxt.out[i] = pick(st_r.out_func[i*FCODE_W +: FCODE_W], sig_pos);
		end

		// Direct mode takes the network data as given. (see R13)
		st_nxt.pdata = (st_r.direct_command_select == DCMD_OFF) ?
			table_data : net_data;

		ev = '0;
		ev[IRQ_STOP] = st_nxt.stop_req && !st_r.stop_req;
		ev[IRQ_TRAVEL] = st_nxt.travel_done_out && !st_r.travel_done_out;
		ev[IRQ_HDONE] = st_nxt.home_done_out && !st_r.home_done_out;
		ev[IRQ_HFAIL] = st_nxt.home_fail_out && !st_r.home_fail_out;

		if (aw_take) begin
			st_nxt.aw_held = 1'b1;
			st_nxt.aw_addr = s_axi_awaddr;
		end
		if (w_take) begin
			st_nxt.w_held = 1'b1;
			st_nxt.w_data = s_axi_wdata;
			st_nxt.w_strb = s_axi_wstrb;
		end
		if (do_wr) begin
			st_nxt.aw_held = 1'b0;
			st_nxt.w_held = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = RESP_OKAY;
			case (st_r.aw_addr)
				A_IN_FUNC: st_nxt.in_func = merge(st_r.in_func,
					st_r.w_data, st_r.w_strb);
				A_OUT_FUNC: st_nxt.out_func = merge(st_r.out_func,
					st_r.w_data, st_r.w_strb);
				A_LOGIC: if (st_r.w_strb[0]) begin
					st_nxt.terminal_input_logic_select = st_r.w_data[LOGIC_W-1:0];
				end
				A_DECEL: if ((st_r.w_data[SET_W-1:0] >= DECEL_MIN) &&
					(st_r.w_data[SET_W-1:0] <= DECEL_MAX)) begin
					st_nxt.sudden_stop_decel_time = st_r.w_data[SET_W-1:0]; // see R11
				end
				A_INPOS: st_nxt.in_position_width = st_r.w_data[SET_W-1:0];
				A_DONEW: st_nxt.done_width = st_r.w_data[SET_W-1:0];
				A_RETAIN: st_nxt.position_retention_select = st_r.w_data[SET_W-1:0];
				A_DCMD: if ((st_r.w_data[FCODE_W-1:0] == DCMD_OFF) ||
					(st_r.w_data[FCODE_W-1:0] == DCMD_ON)) begin
					st_nxt.direct_command_select = st_r.w_data[FCODE_W-1:0]; // see R12
				end
				A_STATUS: ;
				A_IRQ_ST: st_nxt.irq_st = st_r.irq_st & ~st_r.w_data[IRQ_W-1:0];
				A_IRQ_MSK: st_nxt.irq_msk = st_r.w_data[IRQ_W-1:0];
				default: st_nxt.bresp = RESP_SLVERR;
			endcase
		end else if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end
		st_nxt.irq_st = st_nxt.irq_st | ev;

		case (s_axi_araddr)
			A_IN_FUNC: rd = st_r.in_func;
			A_OUT_FUNC: rd = st_r.out_func;
			A_LOGIC: rd = {29'h0, st_r.terminal_input_logic_select};
			A_DECEL: rd = {16'h0, st_r.sudden_stop_decel_time};
			A_INPOS: rd = {16'h0, st_r.in_position_width};
			A_DONEW: rd = {16'h0, st_r.done_width};
			A_RETAIN: rd = {16'h0, st_r.position_retention_select};
			A_DCMD: rd = {24'h0, st_r.direct_command_select};
			A_STATUS: rd = {23'h0, st_r.dog, st_r.stop_req, st_r.ready_out,
				st_r.home_done_out, st_r.positioning_busy_out,
				st_r.home_fail_out, st_r.in_position_out,
				st_r.limit_warning_out, st_r.travel_done_out};
			A_IRQ_ST: rd = {28'h0, st_r.irq_st};
			A_IRQ_MSK: rd = {28'h0, st_r.irq_msk};
			default: rd_ok = 1'b0;
		endcase
		if (ar_take) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata = rd;
			st_nxt.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= '0;
			st_r.sudden_stop_decel_time <= DECEL_RST;
			st_r.in_position_width <= INPOS_RST;
			st_r.done_width <= DONEW_RST;
			st_r.position_retention_select <= RETAIN_RST;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// Outputs
	assign s_axi_awready = !st_r.aw_held && !st_r.bvalid;
	assign s_axi_wready = !st_r.w_held && !st_r.bvalid;
	assign s_axi_bvalid = st_r.bvalid;
	assign s_axi_bresp = st_r.bresp;
	assign s_axi_arready = !st_r.rvalid;
	assign s_axi_rvalid = st_r.rvalid;
	assign s_axi_rdata = st_r.rdata;
	assign s_axi_rresp = st_r.rresp;
	assign out_term = st_r.out;
	assign pos_data = st_r.pdata;
	assign decel_stop_req = st_r.stop_req;
	assign stop_decel_time = st_r.sudden_stop_decel_time;
	assign direct_mode = st_r.direct_command_select != DCMD_OFF;
	assign proximity_dog_input = st_r.dog;
	assign irq = |(st_r.irq_st & st_r.irq_msk);

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence hdone_held;
		ce && st_r.home_done_out && !motion.home_finish;
	endsequence

	stop_request_a: assert property (ce && stop_act |=> st_r.stop_req) // see R1
		else $error("Stop input did not raise stop request.");
	travel_done_a: assert property (ce |=> st_r.travel_done_out ==
		(!$past(motion.busy) && $past(done_now))) // see R2
		else $error("Travel done level wrong.");
	limit_warn_a: assert property (ce && (fwd_act || rev_act)
		|=> st_r.limit_warning_out) // see R3
		else $error("Limit warning missing.");
	in_position_a: assert property (ce |=> st_r.in_position_out ==
		$past(inpos_now)) // see R4
		else $error("In-position level wrong.");
	home_fail_a: assert property (ce && motion.home_warn
		|=> st_r.home_fail_out) // see R5
		else $error("Home fail not following warning.");
	busy_follow_a: assert property (ce |=> st_r.positioning_busy_out ==
		$past(motion.busy)) // see R6
		else $error("Busy output wrong.");
	home_done_a: assert property (ce && motion.home_finish
		|=> st_r.home_done_out) // see R7
		else $error("Home done not set.");
	ready_level_a: assert property (ce |=> st_r.ready_out ==
		($past(motion.servo_lock) &&
		$past(motion.drive_ok))) // see R8
		else $error("Ready output wrong.");
	hdone_clear_a: assert property (hdone_held and (ce && hdone_clear)
		|=> !st_r.home_done_out) // see R9
		else $error("Home done not cleared.");
	hdone_keep_a: assert property (hdone_held and (ce && !hdone_clear)
		|=> st_r.home_done_out) // see R10
		else $error("Home done dropped.");
	decel_range_a: assert property (st_r.sudden_stop_decel_time >= DECEL_MIN
		&& st_r.sudden_stop_decel_time <= DECEL_MAX) // see R11
		else $error("Decel time out of range.");
	dcmd_values_a: assert property (st_r.direct_command_select == DCMD_OFF
		|| st_r.direct_command_select == DCMD_ON) // see R12
		else $error("Direct mode value illegal.");
	neg_invert_a: assert property (ce &&
		st_r.out_func[FCODE_W +: FCODE_W] == OC_LIMIT + OC_NEG_OFS
		|=> out_term[1] != st_r.limit_warning_out) // see R15
		else $error("Negative code not inverted.");

endmodule

// [include/pos_status_pkg.sv]
// Constants, codes, register map and carrier types for the position status block.
package pos_status_pkg;

	// ==========================================================
	// Sizes
	localparam int NUM_IN = 4;
	localparam int NUM_OUT = 4;
	localparam int FCODE_W = 8;
	localparam int SET_W = 16;
	localparam int DROOP_W = 32;
	localparam int POS_W = 32;
	localparam int ADDR_W = 8;
	localparam int IRQ_W = 4;

	// ==========================================================
	// Input terminal function codes
	localparam logic [FCODE_W-1:0] FC_DOG = 8'h4C;
	localparam logic [FCODE_W-1:0] FC_STOP = 8'h57;
	localparam logic [FCODE_W-1:0] FC_FWD = 8'h58;
	localparam logic [FCODE_W-1:0] FC_REV = 8'h59;

	// ==========================================================
	// Output terminal function codes, positive logic, and the offset that makes a negative-logic code
	localparam logic [FCODE_W-1:0] OC_LIMIT = 8'h18;
	localparam logic [FCODE_W-1:0] OC_INPOS = 8'h24;
	localparam logic [FCODE_W-1:0] OC_TRAVEL = 8'h26;
	localparam logic [FCODE_W-1:0] OC_HFAIL = 8'h38;
	localparam logic [FCODE_W-1:0] OC_BUSY = 8'h3D;
	localparam logic [FCODE_W-1:0] OC_HDONE = 8'h3F;
	localparam logic [FCODE_W-1:0] OC_READY = 8'h54;
	localparam logic [FCODE_W-1:0] OC_NEG_OFS = 8'h64;

	// ==========================================================
	// Settings: decel time in units of 0.01 s, retention, direct mode
	localparam logic [SET_W-1:0] DECEL_MIN = 16'h0001;
	localparam logic [SET_W-1:0] DECEL_MAX = 16'h8CA0;
	localparam logic [SET_W-1:0] DECEL_RST = 16'h0001;
	localparam logic [SET_W-1:0] RETAIN_OFF = 16'h270F;
	localparam logic [SET_W-1:0] RETAIN_RST = 16'h270F;
	localparam logic [SET_W-1:0] INPOS_RST = 16'h0064;
	localparam logic [SET_W-1:0] DONEW_RST = 16'h0064;
	localparam logic [FCODE_W-1:0] DCMD_OFF = 8'h00;
	localparam logic [FCODE_W-1:0] DCMD_ON_RST = 8'h03;
	localparam int LOGIC_STOP_BIT = 0;
	localparam int LOGIC_FWD_BIT = 1;
	localparam int LOGIC_REV_BIT = 2;
	localparam int LOGIC_W = 3;

	// ==========================================================
	// Register byte offsets
	localparam logic [ADDR_W-1:0] A_IN_FUNC = 8'h00;
	localparam logic [ADDR_W-1:0] A_OUT_FUNC = 8'h04;
	localparam logic [ADDR_W-1:0] A_LOGIC = 8'h08;
	localparam logic [ADDR_W-1:0] A_DECEL = 8'h0C;
	localparam logic [ADDR_W-1:0] A_INPOS = 8'h10;
	localparam logic [ADDR_W-1:0] A_DONEW = 8'h14;
	localparam logic [ADDR_W-1:0] A_RETAIN = 8'h18;
	localparam logic [ADDR_W-1:0] A_DCMD = 8'h1C;
	localparam logic [ADDR_W-1:0] A_STATUS = 8'h20;
	localparam logic [ADDR_W-1:0] A_IRQ_ST = 8'h24;
	localparam logic [ADDR_W-1:0] A_IRQ_MSK = 8'h28;

	// ==========================================================
	// Interrupt bits and bus responses
	localparam int IRQ_STOP = 0;
	localparam int IRQ_TRAVEL = 1;
	localparam int IRQ_HDONE = 2;
	localparam int IRQ_HFAIL = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Carrier types
	typedef struct packed {
		logic busy;
		logic [DROOP_W-1:0] droop;
		logic home_warn;
		logic home_finish;
		logic servo_lock;
		logic drive_ok;
		logic pos_ctrl_sel;
	} motion_status_t;

	typedef struct packed {
		logic [POS_W-1:0] target;
		logic [SET_W-1:0] max_speed;
		logic [SET_W-1:0] accel_time;
		logic [SET_W-1:0] decel_time;
		logic [SET_W-1:0] home_cfg;
	} pos_data_t;

endpackage

// [tb/pos_partner.sv]
// Far-side model: terminal controller and network master.
`timescale 1ns/100ps
module pos_partner (
	// Clock and requested pin levels
	input wire logic clk,
	input wire logic [3:0] want,
	// Terminal pins and network position data
	output logic [3:0] in_term,
	output pos_status_pkg::pos_data_t net_data
);
	import pos_status_pkg::*;
	// ==========================================================
	// Pins change just after a clock edge.
	initial in_term = 4'h0;
	always @(posedge clk) begin
		in_term <= want;
	end
	// ==========================================================
	// The network master supplies the position data.
	assign net_data = {32'hABCD_0123, 16'h0456, 16'h0789, 16'h0ABC, 16'h0DEF};
endmodule

// [tb/position_status_signals_tb_top.sv]
// Self-checking testbench for the position status block.
`timescale 1ns/100ps
module position_status_signals_tb_top;
	import pos_status_pkg::*;
	// ==========================================================
	// Signals
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic ce = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [31:0] rv;
	logic awready, wready, bvalid, arready, rvalid, irq, stop_req, dmode, dog;
	logic [1:0] bresp, rresp, rsp;
	logic [3:0] pins = 4'h0;
	logic [3:0] in_term, out_term;
	logic [15:0] dtime;
	motion_status_t mot = '0;
	pos_data_t tbl, net, pdata;
	int fail_count = 0;
	int cmp_count = 0;
	logic [15:0] dv [4] = '{16'h8CA0, 16'h0000, 16'h8CA1, 16'h0001};
	logic [15:0] de [4] = '{16'h8CA0, 16'h8CA0, 16'h8CA0, 16'h0001};
	logic [7:0] cv [4] = '{8'h05, 8'h03, 8'h04, 8'h00};
	logic [7:0] ce_exp [4] = '{8'h00, 8'h03, 8'h03, 8'h00};
	logic [3:0] sp [2] = '{4'h4, 4'h8};
	logic [15:0] kv [2] = '{16'h270F, 16'h0000};

	always #2 clk = ~clk;
	assign tbl = {32'h0000_1111, 16'h0022, 16'h0033, 16'h0044, 16'h0055};

	position_status_signals position_status_signals_i (
		.clk(clk), .sys_rst(sys_rst), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .in_term(in_term), .out_term(out_term),
		.motion(mot), .table_data(tbl), .net_data(net), .pos_data(pdata),
		.decel_stop_req(stop_req), .stop_decel_time(dtime),
		.direct_mode(dmode), .proximity_dog_input(dog), .irq(irq)
	);
	pos_partner pos_partner_i (.clk(clk), .want(pins), .in_term(in_term),
		.net_data(net));

	// ==========================================================
	// Tasks
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic timeout();
		fail_count++;
		$display("mismatch bus answer expected 1 seen 0");
		report_and_stop();
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				rsp = bresp;
				bready <= 1'b0;
				@(posedge clk);
				return;
			end
		end
		timeout();
	endtask

	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				rv = rdata;
				rsp = rresp;
				rready <= 1'b0;
				@(posedge clk);
				return;
			end
		end
		timeout();
	endtask

	task automatic rchk(input string name, input logic [7:0] a,
		input logic [31:0] m, input logic [31:0] e);
		rd(a);
		chk(name, rv & m, e);
	endtask

	task automatic st(input string name, input int b, input logic v);
		tick(6);
		rd(A_STATUS);
		chk(name, {31'h0, rv[b]}, {31'h0, v});
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		tick(12);
		sys_rst <= 1'b0;
		tick(1);
		rchk("decel reset", A_DECEL, 32'hFFFF, 32'h1);
		rchk("retain reset", A_RETAIN, 32'hFFFF, 32'h270F);
		rchk("direct reset", A_DCMD, 32'hFF, 32'h0);
		rd(8'h2C);
		chk("unmapped resp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
		wr(8'h2C, 32'h0);
		chk("unmapped wresp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
		for (int i = 0; i < 4; i++) begin
			wr(A_DECEL, {16'h0, dv[i]});
			chk("write resp", {30'h0, rsp}, {30'h0, RESP_OKAY});
			rchk("decel", A_DECEL, 32'hFFFF, {16'h0, de[i]});
			chk("decel port", {16'h0, dtime}, {16'h0, de[i]});
		end
		for (int i = 0; i < 4; i++) begin
			wr(A_DCMD, {24'h0, cv[i]});
			rchk("direct", A_DCMD, 32'hFF, {24'h0, ce_exp[i]});
			tick(2);
			chk("direct mode", {31'h0, dmode}, {31'h0, ce_exp[i] != 8'h0});
			chk("pos data", pdata.target,
				(ce_exp[i] != 8'h0) ? net.target : tbl.target);
		end
		$display("test registers done");
		wr(A_IN_FUNC, {FC_REV, FC_FWD, FC_STOP, FC_DOG});
		wr(A_OUT_FUNC, {OC_BUSY, OC_INPOS, OC_LIMIT + OC_NEG_OFS, OC_LIMIT});
		wr(A_IRQ_MSK, 32'h0);
		wr(A_IRQ_ST, 32'hF);
		mot.pos_ctrl_sel <= 1'b1;
		tick(6);
		chk("out idle", {28'h0, out_term}, 32'h6);
		pins <= 4'h2;
		st("stop", 7, 1'b1);
		chk("stop port", {31'h0, stop_req}, 32'h1);
		chk("irq masked", {31'h0, irq}, 32'h0);
		rchk("irq status", A_IRQ_ST, 32'h1, 32'h1);
		wr(A_IRQ_MSK, 32'h1);
		chk("irq on", {31'h0, irq}, 32'h1);
		pins <= 4'h1;
		st("stop off", 7, 1'b0);
		chk("stop port off", {31'h0, stop_req}, 32'h0);
		wr(A_IRQ_ST, 32'h1);
		chk("irq clear", {31'h0, irq}, 32'h0);
		chk("dog", {31'h0, dog}, 32'h1);
		wr(A_LOGIC, 32'h1);
		st("stop nc", 7, 1'b1);
		pins <= 4'h3;
		st("stop nc off", 7, 1'b0);
		wr(A_LOGIC, 32'h0);
		for (int i = 0; i < 2; i++) begin
			pins <= sp[i];
			st("stroke stop", 7, 1'b1);
			chk("limit out", {28'h0, out_term}, 32'h5);
		end
		mot.pos_ctrl_sel <= 1'b0;
		st("stroke off", 7, 1'b0);
		st("limit bit", 1, 1'b1);
		pins <= 4'h0;
		mot.pos_ctrl_sel <= 1'b1;
		mot.busy <= 1'b1;
		mot.droop <= 32'h64;
		st("travel busy", 0, 1'b0);
		chk("inpos edge", {28'h0, out_term}, 32'hE);
		mot.droop <= 32'h65;
		tick(6);
		chk("inpos over", {28'h0, out_term}, 32'hA);
		mot.busy <= 1'b0;
		mot.droop <= 32'h32;
		st("travel done", 0, 1'b1);
		chk("busy off", {28'h0, out_term}, 32'h6);
		ce <= 1'b0;
		mot.busy <= 1'b1;
		tick(4);
		chk("frozen", {28'h0, out_term}, 32'h6);
		ce <= 1'b1;
		tick(3);
		chk("unfrozen", {28'h0, out_term}, 32'hE);
		mot.busy <= 1'b0;
		$display("test terminals done");
		mot.home_warn <= 1'b1;
		st("home fail", 3, 1'b1);
		mot.home_warn <= 1'b0;
		st("home fail off", 3, 1'b0);
		mot.servo_lock <= 1'b1;
		mot.drive_ok <= 1'b1;
		st("ready", 6, 1'b1);
		mot.drive_ok <= 1'b0;
		st("ready off", 6, 1'b0);
		for (int i = 0; i < 2; i++) begin
			wr(A_RETAIN, {16'h0, kv[i]});
			mot.servo_lock <= 1'b1;
			mot.home_finish <= 1'b1;
			tick(1);
			mot.home_finish <= 1'b0;
			st("home done", 5, 1'b1);
			mot.servo_lock <= 1'b0;
			st("home kept", 5, i == 1);
		end
		rchk("irq events", A_IRQ_ST, 32'hE, 32'hE);
		$display("test home done");
		report_and_stop();
	end
endmodule
